//--- hw/cag_core.sv
/*
 * Address generation of the processor core: next instruction pointer,
 * operand effective addresses, stack pointer and implied accumulator ops.
 * Assumes the decoder holds one request per cycle and that memory answers
 * a table read with an acknowledge while the request stands.
 */
module cag_core (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,

	// Bank select
	input wire logic bank_sel_bit0,
	input wire logic bank_sel_bit1,

	// Instruction flow request
	input wire logic pc_step,
	input wire cag_pkg::cag_pc_mode_t pc_mode,
	input wire logic [2:0] instr_len,
	input wire logic [15:0] imm16,
	input wire logic [7:0] rel_displacement,

	// Vector table read
	output logic tbl_req,
	output logic [15:0] tbl_addr,
	input wire logic tbl_ack,
	input wire logic [15:0] tbl_data,

	// Instruction pointer
	output logic [15:0] instr_pointer,
	output logic pc_busy,

	// Operand address request
	input wire logic ea_req,
	input wire cag_pkg::cag_ea_mode_t ea_mode,
	input wire logic [2:0] reg_code,
	input wire logic [1:0] stack_cnt,

	// Operand address answer
	output logic ea_valid,
	output logic [15:0] ea_addr,
	output logic ea_fault,
	output logic [7:0] reg_data,

	// Stack pointer
	input wire logic sp_load,
	input wire logic [15:0] sp_wdata,
	output logic [15:0] stack_ptr,

	// Register writes from the datapath
	input wire logic rf_we,
	input wire logic [2:0] rf_code,
	input wire logic [7:0] rf_wdata,
	input wire logic rf_pair_we,
	input wire logic [1:0] rf_pair_code,
	input wire logic [15:0] rf_pair_wdata,

	// Implied accumulator operations
	input wire logic imp_req,
	input wire cag_pkg::cag_imp_op_t imp_op,
	input wire logic [7:0] mem_rdata,
	input wire logic carry_in,
	input wire logic aux_carry_in,
	output logic imp_done,
	output logic [7:0] mem_wdata
);

	// ****************************************
	// Reset synchroniser
	// ****************************************
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	cag_rf_if rfi ();

	cag_regfile u_rf (
		.clk(clk),
		.rst_n(rst_n_q),
		.rf(rfi.rf)
	);

	logic [7:0] reg_a;
	logic [7:0] reg_x;
	logic [7:0] reg_b;
	logic [7:0] reg_c;
	logic [15:0] accum_pair;
	logic [15:0] pointer_pair;
	logic [15:0] base_pair;

	assign rfi.bank = {bank_sel_bit1, bank_sel_bit0};
	assign reg_a = rfi.cur[cag_pkg::REG_A];
	assign reg_x = rfi.cur[cag_pkg::REG_X];
	assign reg_b = rfi.cur[cag_pkg::REG_B];
	assign reg_c = rfi.cur[cag_pkg::REG_C];
	assign accum_pair = {rfi.cur[{cag_pkg::PAIR_AX, 1'b1}], rfi.cur[{cag_pkg::PAIR_AX, 1'b0}]};
	assign pointer_pair = {rfi.cur[{cag_pkg::PAIR_DE, 1'b1}], rfi.cur[{cag_pkg::PAIR_DE, 1'b0}]};
	assign base_pair = {rfi.cur[{cag_pkg::PAIR_HL, 1'b1}], rfi.cur[{cag_pkg::PAIR_HL, 1'b0}]};

	// ****************************************
	// Next instruction pointer
	// ****************************************
	logic [15:0] pc_q;
	logic [15:0] pc_d;
	logic [15:0] seq_pc;
	logic [15:0] rel_pc;
	logic [15:0] short_pc;
	logic [15:0] tbl_entry;
	logic take_step;
	logic start_tbl;
	logic end_tbl;

	cag_add #(
		.SEXT(1'b0)
	) u_add_seq (
		.base(pc_q),
		.offset({5'h00, instr_len}),
		.sum(seq_pc)
	);

	cag_add #(
		.SEXT(1'b1)
	) u_add_rel (
		.base(seq_pc),
		.offset(rel_displacement),
		.sum(rel_pc)
	);

	assign short_pc = {cag_pkg::SHORT_CALL_HI, imm16[10:0]};
	assign tbl_entry = {cag_pkg::TBL_BASE[15:6], imm16[5:1], 1'b0};

	assign pc_d = (pc_mode == cag_pkg::PC_REL) ? rel_pc :
		(pc_mode == cag_pkg::PC_IMM) ? imm16 :
		(pc_mode == cag_pkg::PC_SHORT) ? short_pc :
		(pc_mode == cag_pkg::PC_REG) ? accum_pair :
		seq_pc;

	// ****************************************
	// Table call sequencer
	// ****************************************
	cag_pkg::cag_state_t state_q;
	cag_pkg::cag_state_t state_d;
	logic [15:0] tbl_addr_q;

	assign take_step = pc_step && (state_q == cag_pkg::ST_IDLE);
	assign start_tbl = take_step && (pc_mode == cag_pkg::PC_TABLE);
	assign end_tbl = (state_q == cag_pkg::ST_TBL) && tbl_ack;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			cag_pkg::ST_IDLE: begin
				if (start_tbl) begin
					state_d = cag_pkg::ST_TBL;
				end
			end
			cag_pkg::ST_TBL: begin
				if (tbl_ack) begin
					state_d = cag_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = cag_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= cag_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tbl_addr_q <= cag_pkg::TBL_BASE;
		end else if (start_tbl) begin
			tbl_addr_q <= tbl_entry;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pc_q <= cag_pkg::PC_RESET;
		end else if (end_tbl) begin
			pc_q <= tbl_data;
		end else if (take_step && !start_tbl) begin
			pc_q <= pc_d;
		end
	end

	assign tbl_req = (state_q == cag_pkg::ST_TBL);
	assign tbl_addr = tbl_addr_q;
	assign pc_busy = (state_q == cag_pkg::ST_TBL);
	assign instr_pointer = pc_q;

	// ****************************************
	// Operand effective address
	// ****************************************
	logic [15:0] saddr_ea;
	logic [15:0] sfr_ea;
	logic [15:0] based_ea;
	logic [15:0] idx_b_ea;
	logic [15:0] idx_c_ea;
	logic [15:0] push_ea;
	logic [15:0] pop_sp;
	logic [15:0] stk_ea;
	logic [15:0] stk_end;
	logic [15:0] ea_d;
	logic sfr_ext;
	logic stk_mode;
	logic stk_out;
	logic fault_d;
	logic [15:0] sp_q;
	logic [15:0] ea_q;
	logic ea_valid_q;
	logic ea_fault_q;
	logic [7:0] reg_data_q;

	// Bit 8 low for 20H-FFH, high for 00H-1FH
	assign saddr_ea = {cag_pkg::SADDR_HI, imm16[7:0] < cag_pkg::SADDR_SPLIT, imm16[7:0]};
	assign sfr_ea = {cag_pkg::SFR_HI, imm16[7:0]};
	assign sfr_ext = (imm16[7:0] >= cag_pkg::EXT_WIN_LO) && (imm16[7:0] <= cag_pkg::EXT_WIN_HI);

	cag_add #(
		.SEXT(1'b0)
	) u_add_based (
		.base(base_pair),
		.offset(imm16[7:0]),
		.sum(based_ea)
	);

	cag_add #(
		.SEXT(1'b0)
	) u_add_idx_b (
		.base(base_pair),
		.offset(reg_b),
		.sum(idx_b_ea)
	);

	cag_add #(
		.SEXT(1'b0)
	) u_add_idx_c (
		.base(base_pair),
		.offset(reg_c),
		.sum(idx_c_ea)
	);

	// Push pre-decrements, pop reads then increments
	assign push_ea = sp_q - {14'h0000, stack_cnt};
	assign pop_sp = sp_q + {14'h0000, stack_cnt};
	assign stk_mode = (ea_mode == cag_pkg::EA_PUSH) || (ea_mode == cag_pkg::EA_POP);
	assign stk_ea = (ea_mode == cag_pkg::EA_PUSH) ? push_ea : sp_q;
	assign stk_end = stk_ea + {14'h0000, stack_cnt} - 16'h0001;
	assign stk_out = (stk_ea < cag_pkg::HIRAM_LO) || (stk_end > cag_pkg::HIRAM_HI);

	assign ea_d = (ea_mode == cag_pkg::EA_DIR) ? imm16 :
		(ea_mode == cag_pkg::EA_SADDR) ? saddr_ea :
		(ea_mode == cag_pkg::EA_SFR) ? sfr_ea :
		(ea_mode == cag_pkg::EA_IND_DE) ? pointer_pair :
		(ea_mode == cag_pkg::EA_IND_HL) ? base_pair :
		(ea_mode == cag_pkg::EA_BASED) ? based_ea :
		(ea_mode == cag_pkg::EA_IDX_B) ? idx_b_ea :
		(ea_mode == cag_pkg::EA_IDX_C) ? idx_c_ea :
		stk_mode ? stk_ea :
		16'h0000;

	assign fault_d = ((ea_mode == cag_pkg::EA_SFR) && sfr_ext) ||
		(stk_mode && stk_out);

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ea_q <= 16'h0000;
			ea_fault_q <= 1'b0;
			reg_data_q <= cag_pkg::REG_RESET;
		end else if (ea_req) begin
			ea_q <= ea_d;
			ea_fault_q <= fault_d;
			reg_data_q <= rfi.cur[reg_code];
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ea_valid_q <= 1'b0;
		end else begin
			ea_valid_q <= ea_req;
		end
	end

	// Load by software wins over a stack move
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sp_q <= cag_pkg::SP_RESET;
		end else if (sp_load) begin
			sp_q <= sp_wdata;
		end else if (ea_req && (ea_mode == cag_pkg::EA_PUSH)) begin
			sp_q <= push_ea;
		end else if (ea_req && (ea_mode == cag_pkg::EA_POP)) begin
			sp_q <= pop_sp;
		end
	end

	assign ea_valid = ea_valid_q;
	assign ea_addr = ea_q;
	assign ea_fault = ea_fault_q;
	assign reg_data = reg_data_q;
	assign stack_ptr = sp_q;

	// ****************************************
	// Implied accumulator operations
	// ****************************************
	logic [15:0] mul_res;
	logic [15:0] div_quo;
	logic [7:0] div_rem;
	logic adj_lo;
	logic adj_hi;
	logic [7:0] adj_val;
	logic [7:0] adj_add_res;
	logic [7:0] adj_sub_res;
	logic [7:0] rot_a;
	logic [7:0] rot_m;
	logic [7:0] imp_a;
	logic imp_pair;
	logic imp_byte;
	logic imp_mem;
	logic imp_done_q;
	logic [7:0] mem_wdata_q;

	assign mul_res = {8'h00, reg_a} * {8'h00, reg_x};
	// Divide by zero gives all ones and keeps the dividend low byte
	assign div_quo = (reg_c == 8'h00) ? 16'hFFFF : accum_pair / {8'h00, reg_c};
	assign div_rem = (reg_c == 8'h00) ? accum_pair[7:0] : 8'(accum_pair % {8'h00, reg_c});

	assign adj_lo = (reg_a[3:0] > cag_pkg::BCD_MAX) || aux_carry_in;
	assign adj_hi = (reg_a > cag_pkg::BCD_HI_MAX) || carry_in;
	assign adj_val = (adj_lo ? cag_pkg::ADJ_LO : 8'h00) | (adj_hi ? cag_pkg::ADJ_HI : 8'h00);
	assign adj_add_res = reg_a + adj_val;
	assign adj_sub_res = reg_a - adj_val;

	assign rot_a = (imp_op == cag_pkg::IMP_DIGIT_ROTATE_RIGHT) ? {reg_a[7:4], mem_rdata[3:0]} :
		{reg_a[7:4], mem_rdata[7:4]};
	assign rot_m = (imp_op == cag_pkg::IMP_DIGIT_ROTATE_RIGHT) ? {reg_a[3:0], mem_rdata[7:4]} :
		{mem_rdata[3:0], reg_a[3:0]};

	assign imp_pair = imp_req && ((imp_op == cag_pkg::IMP_MUL) || (imp_op == cag_pkg::IMP_DIV));
	assign imp_mem = imp_req && ((imp_op == cag_pkg::IMP_DIGIT_ROTATE_RIGHT) || (imp_op == cag_pkg::IMP_DIGIT_ROTATE_LEFT));
	assign imp_byte = imp_req && !imp_pair;
	assign imp_a = (imp_op == cag_pkg::IMP_ADJ_ADD) ? adj_add_res :
		(imp_op == cag_pkg::IMP_ADJ_SUB) ? adj_sub_res :
		rot_a;

	// Implied results take the write ports ahead of the datapath
	assign rfi.pair_we = imp_pair || rf_pair_we;
	assign rfi.pair_idx = imp_pair ? cag_pkg::PAIR_AX : rf_pair_code;
	assign rfi.pair_wdata = !imp_pair ? rf_pair_wdata :
		(imp_op == cag_pkg::IMP_MUL) ? mul_res : div_quo;

	assign rfi.byte_we = imp_byte || (imp_pair && (imp_op == cag_pkg::IMP_DIV)) || rf_we;
	assign rfi.byte_idx = imp_byte ? cag_pkg::REG_A :
		(imp_pair && (imp_op == cag_pkg::IMP_DIV)) ? cag_pkg::REG_C : rf_code;
	assign rfi.byte_wdata = imp_byte ? imp_a :
		(imp_pair && (imp_op == cag_pkg::IMP_DIV)) ? div_rem : rf_wdata;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			imp_done_q <= 1'b0;
			mem_wdata_q <= 8'h00;
		end else begin
			imp_done_q <= imp_req;
			if (imp_mem) begin
				mem_wdata_q <= rot_m;
			end
		end
	end

	assign imp_done = imp_done_q;
	assign mem_wdata = mem_wdata_q;

endmodule

//--- hw/cag_pkg.sv
/*
 * Constants and types of the core address generation block.
 * Assumes one clock domain and a decoder that presents one request at a time.
 */
// Notes on behaviour
// - Sequential flow adds the fetched instruction length to the instruction pointer.
// - Relative target: sign-extended 8-bit displacement plus next instruction address.
// - Short branch and all conditional branches use the relative target.
// - Long call and long branch load the 16-bit immediate.
// - Short call targets stay inside 0800H to 0FFFH.
// - Table call reads a 16-bit target from 40H to 7FH, selected by bits 1-5.
// - Register branch copies the accumulator pair into the instruction pointer.
// - Multiply takes accumulator and partner bytes, product goes to accumulator pair.
// - Word divide reads and writes the accumulator pair.
// - Decimal adjust and digit rotate work on the accumulator byte implicitly.
// - A 3-bit code picks one of eight byte registers of the selected bank.
// - Direct addressing uses the 16-bit immediate as address.
// - Short direct reaches only FE20H to FF1FH.
// - Short direct address bit 8 is set only for immediates 00H to 1FH.
// - Special-register address is FF00H plus the 8-bit immediate.
// - Register indirect uses pointer or base pair of the selected bank.
// - Based: zero-extended offset plus base pair, carry dropped.
// - Based indexed: zero-extended index byte plus base pair, carry dropped.
// - Push, pop, call, return and interrupt saving use the stack pointer; this block moves it only for push and pop.
// - Stack accesses may target only internal high-speed RAM.
// - External window FFD0H to FFDFH is refused by special-register addressing.
// - Four banks of eight byte registers, bank chosen by two select bits.
package cag_pkg;

	// ****************************************
	// Address map
	// ****************************************
	localparam logic [4:0] SHORT_CALL_HI = 5'h01;
	localparam logic [15:0] TBL_BASE = 16'h0040;
	localparam logic [7:0] SADDR_SPLIT = 8'h20;
	localparam logic [6:0] SADDR_HI = 7'h7F;
	localparam logic [7:0] SFR_HI = 8'hFF;
	localparam logic [7:0] EXT_WIN_LO = 8'hD0;
	localparam logic [7:0] EXT_WIN_HI = 8'hDF;
	localparam logic [15:0] HIRAM_LO = 16'hFE20;
	localparam logic [15:0] HIRAM_HI = 16'hFEFF;

	// ****************************************
	// Register file layout
	// ****************************************
	localparam int NUM_BANKS = 4;
	localparam int REGS_PER_BANK = 8;
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [2:0] REG_C = 3'h2;
	localparam logic [2:0] REG_B = 3'h3;
	localparam logic [1:0] PAIR_AX = 2'h0;
	localparam logic [1:0] PAIR_DE = 2'h2;
	localparam logic [1:0] PAIR_HL = 2'h3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// ****************************************
	// Decimal adjust constants
	// ****************************************
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [7:0] BCD_HI_MAX = 8'h99;
	localparam logic [7:0] ADJ_LO = 8'h06;
	localparam logic [7:0] ADJ_HI = 8'h60;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		PC_SEQ = 3'h0, PC_REL = 3'h1, PC_IMM = 3'h3,
		PC_SHORT = 3'h2, PC_TABLE = 3'h6, PC_REG = 3'h7
	} cag_pc_mode_t;

	typedef enum logic [3:0] {
		EA_DIR = 4'h0, EA_SADDR = 4'h1, EA_SFR = 4'h2, EA_IND_DE = 4'h3,
		EA_IND_HL = 4'h4, EA_BASED = 4'h5, EA_IDX_B = 4'h6, EA_IDX_C = 4'h7,
		EA_PUSH = 4'h8, EA_POP = 4'h9, EA_REG = 4'hA
	} cag_ea_mode_t;

	typedef enum logic [2:0] {
		IMP_MUL = 3'h0, IMP_DIV = 3'h1, IMP_ADJ_ADD = 3'h2,
		IMP_ADJ_SUB = 3'h3, IMP_DIGIT_ROTATE_RIGHT = 3'h4, IMP_DIGIT_ROTATE_LEFT = 3'h5
	} cag_imp_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_TBL = 2'h1
	} cag_state_t;

endpackage

//--- hw/cag_rf_if.sv
/*
 * Interface between the core and its register file.
 * Assumes the register file shares the core clock and reset.
 */
interface cag_rf_if;
	logic [1:0] bank;
	logic byte_we;
	logic [2:0] byte_idx;
	logic [7:0] byte_wdata;
	logic pair_we;
	logic [1:0] pair_idx;
	logic [15:0] pair_wdata;
	logic [7:0] cur [0:7];

	modport core (
		output bank, byte_we, byte_idx, byte_wdata, pair_we, pair_idx, pair_wdata,
		input cur
	);

	modport rf (
		input bank, byte_we, byte_idx, byte_wdata, pair_we, pair_idx, pair_wdata,
		output cur
	);
endinterface

//--- hw/cag_add.sv
/*
 * 16-bit address adder with an 8-bit offset.
 * Assumes the carry out of bit 15 is never wanted.
 */
module cag_add #(
	parameter bit SEXT = 1'b0
) (
	// Operands
	input wire logic [15:0] base,
	input wire logic [7:0] offset,
	// Result
	output logic [15:0] sum
);
	logic [15:0] ext;

	// Width of sum drops the carry, so targets wrap
	assign ext = SEXT ? {{8{offset[7]}}, offset} : {8'h00, offset};
	assign sum = base + ext;
endmodule

//--- hw/cag_regfile.sv
/*
 * Banked general register file: four banks of eight bytes.
 * Assumes synchronous reset release by the core.
 */
module cag_regfile (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Core side
	cag_rf_if.rf rf
);
	logic [7:0] mem_q [0:cag_pkg::NUM_BANKS*cag_pkg::REGS_PER_BANK-1];
	logic [4:0] byte_addr;
	logic [4:0] pair_lo;
	logic [4:0] pair_hi;

	assign byte_addr = {rf.bank, rf.byte_idx};
	assign pair_lo = {rf.bank, rf.pair_idx, 1'b0};
	assign pair_hi = {rf.bank, rf.pair_idx, 1'b1};

	genvar g;
	generate
		for (g = 0; g < cag_pkg::REGS_PER_BANK; g++) begin : g_rd
			assign rf.cur[g] = mem_q[{rf.bank, 3'(g)}];
		end
	endgenerate

	// Pair write is last, so it wins a collision
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cag_pkg::NUM_BANKS*cag_pkg::REGS_PER_BANK; i++) begin
				mem_q[i] <= cag_pkg::REG_RESET;
			end
		end else begin
			if (rf.byte_we) begin
				mem_q[byte_addr] <= rf.byte_wdata;
			end
			if (rf.pair_we) begin
				mem_q[pair_lo] <= rf.pair_wdata[7:0];
				mem_q[pair_hi] <= rf.pair_wdata[15:8];
			end
		end
	end
endmodule

//--- verif/cag_core_assertions.sv
/*
 * Concurrent checks on the ports of the address generation core.
 * Assumes one clock domain and the core's declared port list.
 */
module cag_core_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Instruction flow
	input wire logic pc_step,
	input wire cag_pkg::cag_pc_mode_t pc_mode,
	input wire logic [2:0] instr_len,
	input wire logic [15:0] imm16,
	input wire logic [7:0] rel_displacement,
	input wire logic tbl_req,
	input wire logic [15:0] tbl_addr,
	input wire logic tbl_ack,
	input wire logic [15:0] tbl_data,
	input wire logic [15:0] instr_pointer,
	input wire logic pc_busy,
	// Operand address
	input wire logic ea_req,
	input wire cag_pkg::cag_ea_mode_t ea_mode,
	input wire logic [1:0] stack_cnt,
	input wire logic ea_valid,
	input wire logic [15:0] ea_addr,
	input wire logic ea_fault,
	input wire logic sp_load,
	input wire logic [15:0] stack_ptr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] imm_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;
	logic [15:0] tdata_q;
	logic [2:0] len_q;
	logic [7:0] disp_q;
	logic [1:0] cnt_q;
	wire pc_go = pc_step && !pc_busy;
	wire ea_stack = ea_req && (ea_mode == cag_pkg::EA_PUSH || ea_mode == cag_pkg::EA_POP);

	// ****************************************
	// Request capture
	// ****************************************
	always_ff @(posedge clk) begin
		imm_q <= imm16;
		pc_q <= instr_pointer;
		sp_q <= stack_ptr;
		tdata_q <= tbl_data;
		len_q <= instr_len;
		disp_q <= rel_displacement;
		cnt_q <= stack_cnt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ****************************************
	// Checks
	// ****************************************
	a_seq_step: assert property (pc_go && pc_mode == cag_pkg::PC_SEQ |=>
		instr_pointer == pc_q + {13'h0000, len_q}) else $error("sequential step wrong");
	a_rel_target: assert property (pc_go && pc_mode == cag_pkg::PC_REL |=>
		instr_pointer == pc_q + {13'h0000, len_q} + {{8{disp_q[7]}}, disp_q}) else $error("relative target wrong");
	a_long_imm: assert property (pc_go && pc_mode == cag_pkg::PC_IMM |=> instr_pointer == imm_q)
		else $error("immediate target wrong");
	a_short_call: assert property (pc_go && pc_mode == cag_pkg::PC_SHORT |=>
		instr_pointer == {5'h01, imm_q[10:0]}) else $error("short call target wrong");
	a_tbl_addr: assert property (pc_go && pc_mode == cag_pkg::PC_TABLE |=>
		tbl_req && pc_busy && tbl_addr == 16'h0040 + {10'h000, imm_q[5:1], 1'b0}) else $error("table address wrong");
	a_tbl_load: assert property (tbl_req && tbl_ack |=> !tbl_req && instr_pointer == tdata_q)
		else $error("table target not loaded");
	a_direct_addr: assert property (ea_req && ea_mode == cag_pkg::EA_DIR |=>
		ea_valid && ea_addr == imm_q && !ea_fault) else $error("direct address wrong");
	a_saddr_window: assert property (ea_req && ea_mode == cag_pkg::EA_SADDR |=>
		ea_addr >= 16'hFE20 && ea_addr <= 16'hFF1F && ea_addr[7:0] == imm_q[7:0]) else $error("short direct wrong");
	a_sfr_addr: assert property (ea_req && ea_mode == cag_pkg::EA_SFR |=>
		ea_addr == {8'hFF, imm_q[7:0]} && ea_fault == (imm_q[7:4] == 4'hD)) else $error("sfr address wrong");
	a_stack_push: assert property (ea_req && ea_mode == cag_pkg::EA_PUSH && !sp_load |=>
		ea_addr == sp_q - {14'h0000, cnt_q} && stack_ptr == ea_addr) else $error("push address wrong");
	a_stack_fault: assert property (ea_stack |=>
		ea_fault == (ea_addr < 16'hFE20 || ea_addr + {14'h0000, cnt_q} - 16'h0001 > 16'hFEFF))
		else $error("stack range flag wrong");

	c_table: cover property (tbl_req && tbl_ack);
	c_ext_win: cover property (ea_valid && ea_fault);
	c_push: cover property (ea_req && ea_mode == cag_pkg::EA_PUSH);
endmodule

bind cag_core cag_core_assertions cag_core_assertions_inst (.clk, .reset_n, .pc_step, .pc_mode, .instr_len, .imm16,
	.rel_displacement, .tbl_req, .tbl_addr, .tbl_ack, .tbl_data, .instr_pointer, .pc_busy, .ea_req, .ea_mode,
	.stack_cnt, .ea_valid, .ea_addr, .ea_fault, .sp_load, .stack_ptr);

//--- verif/cag_mem_model.sv
/*
 * Vector table memory on the far side of the table read.
 * Assumes the core holds tbl_req until it samples tbl_ack.
 */
module cag_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Table read
	input wire logic tbl_req,
	input wire logic [15:0] tbl_addr,
	output logic tbl_ack,
	output logic [15:0] tbl_data,
	// Answer delay in cycles
	input wire logic [3:0] delay
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ack_q;
	logic [3:0] cnt_q;
	logic [15:0] pat_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			cnt_q <= 4'h0;
			pat_q <= 16'h0000;
		end else begin
			pat_q <= pat_q + 16'h3B5D;
			if (ack_q || !tbl_req) begin
				ack_q <= 1'b0;
				cnt_q <= 4'h0;
			end else if (cnt_q == delay) begin
				ack_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	// Entry content is the inverted address; noise outside the answer
	assign tbl_ack = ack_q;
	assign tbl_data = ack_q ? ~tbl_addr : pat_q;
endmodule

//--- verif/cpu_address_generation_tb.sv
/*
 * Self-checking bench of the address generation core.
 * Assumes the vector table model answers table reads.
 */
module cpu_address_generation_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, bank_sel_bit0, bank_sel_bit1, pc_step, tbl_req, tbl_ack, pc_busy, ea_req, ea_valid;
	logic ea_fault, sp_load, rf_we, rf_pair_we, imp_req, imp_done;
	cag_pkg::cag_pc_mode_t pc_mode;
	cag_pkg::cag_ea_mode_t ea_mode;
	logic [2:0] instr_len, reg_code, rf_code;
	logic [1:0] stack_cnt, rf_pair_code;
	logic [3:0] ack_delay;
	logic [7:0] rel_displacement, reg_data, rf_wdata, mem_wdata;
	logic [15:0] imm16, tbl_addr, tbl_data, instr_pointer, ea_addr, stack_ptr, rf_pair_wdata;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	cag_core cag_core_inst (.clk, .reset_n, .bank_sel_bit0, .bank_sel_bit1, .pc_step, .pc_mode, .instr_len, .imm16,
		.rel_displacement, .tbl_req, .tbl_addr, .tbl_ack, .tbl_data, .instr_pointer, .pc_busy, .ea_req, .ea_mode,
		.reg_code, .stack_cnt, .ea_valid, .ea_addr, .ea_fault, .reg_data, .sp_load, .sp_wdata(16'hFE80), .stack_ptr,
		.rf_we, .rf_code, .rf_wdata, .rf_pair_we, .rf_pair_code, .rf_pair_wdata, .imp_req, .imp_op(cag_pkg::IMP_MUL),
		.mem_rdata(8'h00), .carry_in(1'b0), .aux_carry_in(1'b0), .imp_done, .mem_wdata);

	cag_mem_model cag_mem_model_inst (.clk, .rst_n(reset_n), .tbl_req, .tbl_addr, .tbl_ack, .tbl_data,
		.delay(ack_delay));

	// ****************************************
	// Clock, timeout and verdict
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic pc_go(input cag_pkg::cag_pc_mode_t m, input logic [15:0] imm = 16'h0000,
		input logic [2:0] len = 3'h0, input logic [7:0] d = 8'h00);
		@(negedge clk);
		{pc_step, pc_mode, instr_len, imm16, rel_displacement} = {1'b1, m, len, imm, d};
		@(negedge clk);
		pc_step = 1'b0;
	endtask

	task automatic pair_wr(input logic [1:0] c, input logic [15:0] v);
		@(negedge clk);
		{rf_pair_we, rf_pair_code, rf_pair_wdata} = {1'b1, c, v};
		@(negedge clk);
		rf_pair_we = 1'b0;
	endtask

	task automatic ea_chk(input cag_pkg::cag_ea_mode_t m, input logic [15:0] imm, input logic [15:0] exp_addr,
		input logic exp_fault, input logic [1:0] cnt = 2'h0, input logic [2:0] rc = 3'h0);
		@(negedge clk);
		{ea_req, ea_mode, imm16, reg_code, stack_cnt} = {1'b1, m, imm, rc, cnt};
		@(negedge clk);
		ea_req = 1'b0;
		chk("ea_valid", 16'h0001, {15'h0000, ea_valid});
		chk("ea_addr", exp_addr, ea_addr);
		chk("ea_fault", {15'h0000, exp_fault}, {15'h0000, ea_fault});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_flow();
		pc_go(cag_pkg::PC_IMM, 16'h0010);
		chk("imm target", 16'h0010, instr_pointer);
		pc_go(cag_pkg::PC_SEQ, 16'h0000, 3'h3);
		chk("seq step", 16'h0013, instr_pointer);
		pc_go(cag_pkg::PC_REL, 16'h0000, 3'h2, 8'h80);
		chk("rel back", 16'hFF95, instr_pointer);
		pc_go(cag_pkg::PC_REL, 16'h0000, 3'h2, 8'h7F);
		chk("rel fwd wrap", 16'h0016, instr_pointer);
		pc_go(cag_pkg::PC_SHORT, 16'hFFFF);
		chk("short top", 16'h0FFF, instr_pointer);
		pc_go(cag_pkg::PC_SHORT, 16'hF000);
		chk("short bottom", 16'h0800, instr_pointer);
		pair_wr(2'h0, 16'hF0FE);
		@(negedge clk);
		imp_req = 1'b1;
		@(negedge clk);
		imp_req = 1'b0;
		chk("mul done", 16'h0001, {15'h0000, imp_done});
		pc_go(cag_pkg::PC_REG);
		chk("reg target product", 16'hEE20, instr_pointer);
	endtask

	task automatic t_table(input logic [3:0] d, input logic [15:0] imm, input logic [15:0] entry);
		ack_delay = d;
		pc_go(cag_pkg::PC_TABLE, imm);
		chk("tbl_req", 16'h0001, {15'h0000, tbl_req});
		chk("tbl_addr", entry, tbl_addr);
		if (d > 4'h1)
			pc_go(cag_pkg::PC_IMM, 16'h5555);
		for (int i = 0; i < 20 && tbl_req !== 1'b0; i++)
			@(negedge clk);
		chk("table target", ~entry, instr_pointer);
	endtask

	task automatic t_operand();
		ea_chk(cag_pkg::EA_DIR, 16'hFFD5, 16'hFFD5, 1'b0);
		ea_chk(cag_pkg::EA_SADDR, 16'h001F, 16'hFF1F, 1'b0);
		ea_chk(cag_pkg::EA_SADDR, 16'h0020, 16'hFE20, 1'b0);
		ea_chk(cag_pkg::EA_SADDR, 16'h00FF, 16'hFEFF, 1'b0);
		ea_chk(cag_pkg::EA_SFR, 16'h00CF, 16'hFFCF, 1'b0);
		ea_chk(cag_pkg::EA_SFR, 16'h00D0, 16'hFFD0, 1'b1);
		ea_chk(cag_pkg::EA_SFR, 16'h00DF, 16'hFFDF, 1'b1);
		ea_chk(cag_pkg::EA_SFR, 16'h00E0, 16'hFFE0, 1'b0);
		pair_wr(2'h2, 16'h8001);
		pair_wr(2'h3, 16'hFFF0);
		pair_wr(2'h1, 16'h2030);
		ea_chk(cag_pkg::EA_IND_DE, 16'h0000, 16'h8001, 1'b0);
		ea_chk(cag_pkg::EA_IND_HL, 16'h0000, 16'hFFF0, 1'b0);
		ea_chk(cag_pkg::EA_BASED, 16'h0080, 16'h0070, 1'b0);
		ea_chk(cag_pkg::EA_IDX_B, 16'h0000, 16'h0010, 1'b0);
		ea_chk(cag_pkg::EA_IDX_C, 16'h0000, 16'h0020, 1'b0);
		ea_chk(cag_pkg::EA_POP, 16'h0000, 16'h0000, 1'b1, 2'h1);
		@(negedge clk);
		sp_load = 1'b1;
		@(negedge clk);
		sp_load = 1'b0;
		ea_chk(cag_pkg::EA_PUSH, 16'h0000, 16'hFE7D, 1'b0, 2'h3);
		chk("sp after push", 16'hFE7D, stack_ptr);
		ea_chk(cag_pkg::EA_POP, 16'h0000, 16'hFE7D, 1'b0, 2'h3);
		chk("sp after pop", 16'hFE80, stack_ptr);
	endtask

	task automatic t_bank();
		logic [7:0] exp;
		@(negedge clk);
		{bank_sel_bit1, bank_sel_bit0} = 2'h1;
		{rf_we, rf_code, rf_wdata} = {1'b1, 3'h5, 8'h5A};
		@(negedge clk);
		rf_we = 1'b0;
		for (int b = 0; b < 4; b++) begin
			{bank_sel_bit1, bank_sel_bit0} = b[1:0];
			exp = (b == 0) ? 8'h80 : ((b == 1) ? 8'h5A : 8'h00);
			ea_chk(cag_pkg::EA_REG, 16'h0000, 16'h0000, 1'b0, 2'h0, 3'h5);
			chk("reg_data", {8'h00, exp}, {8'h00, reg_data});
		end
	endtask

	initial begin
		{reset_n, bank_sel_bit0, bank_sel_bit1, pc_step, ea_req, sp_load, rf_we, rf_pair_we, imp_req} = '0;
		{instr_len, imm16, rel_displacement, reg_code, stack_cnt, rf_code, rf_wdata} = '0;
		{rf_pair_code, rf_pair_wdata} = '0;
		pc_mode = cag_pkg::PC_SEQ;
		ea_mode = cag_pkg::EA_DIR;
		ack_delay = 4'h0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		t_flow();
		t_table(4'h4, 16'h003E, 16'h007E);
		t_table(4'h0, 16'h0002, 16'h0042);
		t_operand();
		t_bank();
		tally_and_finish();
	end
endmodule
